// >>> src/cfsl_pkg.sv
// cfsl_pkg: constants, types and register map of the controller fault-status logic.
// assumes: one 100 MHz clock domain; APB slave with 32-bit data.
package cfsl_pkg;
    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATE = 8'h02;
    localparam logic [7:0] IDX_MINOR = 8'h05;
    localparam logic [7:0] IDX_MAJOR = 8'h06;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
    localparam int IDX_SHIFT = 2;

    // ----------------------------------------------------------------
    // minor-fault word bit positions and masks
    // ----------------------------------------------------------------
    localparam int MB_OVERFLOW = 0;
    localparam int MB_CTRL_REG = 2;
    localparam int MB_FAULT_IN_FAULT = 3;
    localparam int MB_RETAIN_LOST = 8;
    localparam int MB_PTI_OVERRUN = 10;
    localparam int MB_FILTER_ADJ = 13;
    localparam logic [15:0] MINOR_IMPL_MASK = 16'h250D;
    localparam logic [15:0] MINOR_LOW_MASK = 16'h00FF;
    localparam logic [15:0] MINOR_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // control and interrupt bit positions
    // ----------------------------------------------------------------
    localparam int CB_HALT = 0;
    localparam int IB_FAULT = 0;
    localparam int IB_RETAIN = 1;
    localparam int IB_PTI = 2;
    localparam int IB_FILTER = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [15:0] MAJOR_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // fault codes, hexadecimal
    // ----------------------------------------------------------------
    localparam logic [15:0] FC_DEFAULT_PROG = 16'h0001;
    localparam logic [15:0] FC_UNEXP_RESET = 16'h0002;
    localparam logic [15:0] FC_NVM_CORRUPT = 16'h0003;
    localparam logic [15:0] FC_RETAIN_LOST = 16'h0005;
    localparam logic [15:0] FC_PGM_DEV = 16'h0008;
    localparam logic [15:0] FC_INT_HW = 16'h0009;
    localparam logic [15:0] FC_MINOR_EOS = 16'h0020;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CFSL_NON_USER,
        CFSL_NON_RECOV,
        CFSL_RECOV
    } cfsl_class_t;

    typedef enum logic [1:0] {
        CFSL_RUN,
        CFSL_FAULT_RTN,
        CFSL_HALTED
    } cfsl_mode_t;

    // events and levels from the scan engine, same clock
    typedef struct packed {
        logic [7:0] minor_set;
        logic retain_lost;
        logic pti_expire;
        logic pti_busy;
        logic pti_pending;
        logic filter_adjusted;
        logic first_scan_req;
        logic scan_end;
        logic fault_req;
        logic [15:0] fault_code;
        cfsl_class_t fault_class;
        logic fault_rtn_done;
        logic pu_default_prog;
        logic pu_unexp_reset;
        logic pu_nvm_corrupt;
        logic pu_pgm_dev;
        logic pu_int_hw;
    } cfsl_engine_t;

    // complete state of the block
    typedef struct packed {
        logic [15:0] minor;
        logic [15:0] major;
        logic halt;
        cfsl_class_t cls;
        cfsl_mode_t mode;
        logic run_rtn;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
        logic pslverr;
    } cfsl_state_t;
endpackage : cfsl_pkg

// >>> src/cfsl_top.sv
// cfsl_top: fault-status logic of a programmable controller, APB register slave.
// assumes: scan engine inputs are on pclk; APB master holds requests until pready.
//
// How it works
// - fault during fault routine sets a flag; major code holds that new fault
// - retained-data-lost flag is set each time retained data is lost
// - retained-data-lost flag only clears by a software write
// - first scan request with retained-data-lost set declares a fault first
// - periodic timer expiring while busy and already pending sets overrun flag
// - input-filter-adjusted flag is set when the filter selection is changed
// - declaring a major fault loads its code and sets the halt flag
// - major code word is never cleared by hardware, only overwritten
// - software writing a code then setting halt raises its own major fault
// - fault codes are held and read back in hexadecimal form
// - non-user fault stops the program without running the fault routine
// - non-recoverable user fault runs the routine but stays latched
// - recoverable fault runs the routine; clearing halt before the routine ends resumes operation
// - powerup codes 0001, 0002, 0003 for default program, reset, memory corrupt
// - powerup codes 0008 and 0009 for programming-device and hardware errors
// - low minor bits still set at scan end declare recoverable fault 0020
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module cfsl_top #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cfsl_pkg::cfsl_engine_t eng,
    output logic halt,
    output logic program_stop,
    output logic run_fault_routine,
    output logic [15:0] major_code,
    output logic irq
);
    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (ADDR_W < 6) begin : g_addr_w_check
        $error("cfsl_top: ADDR_W too small for register map");
    end

    cfsl_pkg::cfsl_state_t s_r;
    cfsl_pkg::cfsl_state_t s_nxt;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic setup_ph;
    logic access_wr;
    logic [7:0] idx;
    logic idx_ok;
    logic lo_en;
    logic hi_en;
    logic [15:0] wmask;

    // word index from byte address, strobes make a 16-bit write mask
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign idx = 8'(paddr >> cfsl_pkg::IDX_SHIFT);
    assign lo_en = pstrb[0];
    assign hi_en = pstrb[1];
    assign wmask = {{8{hi_en}}, {8{lo_en}}};
    assign idx_ok = (idx == cfsl_pkg::IDX_CTRL) | (idx == cfsl_pkg::IDX_STATE)
        | (idx == cfsl_pkg::IDX_MINOR) | (idx == cfsl_pkg::IDX_MAJOR)
        | (idx == cfsl_pkg::IDX_IRQ_STAT) | (idx == cfsl_pkg::IDX_IRQ_MASK);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic wr_minor;
    logic wr_major;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic sw_halt_set;
    logic sw_halt_clr;
    logic declare;
    logic [15:0] dcode;
    cfsl_pkg::cfsl_class_t dclass;
    logic [15:0] minor_set;
    logic [15:0] minor_clr;
    logic [cfsl_pkg::IRQ_W-1:0] irq_set;
    logic [15:0] major_w;

    always_comb begin
        s_nxt = s_r;
        wr_minor = access_wr & (idx == cfsl_pkg::IDX_MINOR);
        wr_major = access_wr & (idx == cfsl_pkg::IDX_MAJOR);
        wr_ctrl = access_wr & (idx == cfsl_pkg::IDX_CTRL) & lo_en;
        wr_istat = access_wr & (idx == cfsl_pkg::IDX_IRQ_STAT) & lo_en;
        wr_imask = access_wr & (idx == cfsl_pkg::IDX_IRQ_MASK) & lo_en;
        sw_halt_set = wr_ctrl & pwdata[cfsl_pkg::CB_HALT] & ~s_r.halt;
        sw_halt_clr = wr_ctrl & ~pwdata[cfsl_pkg::CB_HALT];
        minor_set = 16'h0000;
        irq_set = cfsl_pkg::IRQ_RESET;
        declare = 1'b0;
        dcode = s_r.major;
        dclass = cfsl_pkg::CFSL_NON_USER;

        // status flag events from the scan engine
        minor_set[cfsl_pkg::MB_OVERFLOW] = eng.minor_set[cfsl_pkg::MB_OVERFLOW];
        minor_set[cfsl_pkg::MB_CTRL_REG] = eng.minor_set[cfsl_pkg::MB_CTRL_REG];
        if (eng.retain_lost) begin
            minor_set[cfsl_pkg::MB_RETAIN_LOST] = 1'b1;
            irq_set[cfsl_pkg::IB_RETAIN] = 1'b1;
        end
        if (eng.pti_expire & eng.pti_busy & eng.pti_pending) begin
            minor_set[cfsl_pkg::MB_PTI_OVERRUN] = 1'b1;
            irq_set[cfsl_pkg::IB_PTI] = 1'b1;
        end
        if (eng.filter_adjusted) begin
            minor_set[cfsl_pkg::MB_FILTER_ADJ] = 1'b1;
            irq_set[cfsl_pkg::IB_FILTER] = 1'b1;
        end

        // fault sources, highest priority last
        if (sw_halt_set) begin
            declare = 1'b1;
            dcode = wr_major ? pwdata[15:0] : s_r.major;
            dclass = cfsl_pkg::CFSL_RECOV;
        end
        if (eng.scan_end & |(s_r.minor & cfsl_pkg::MINOR_LOW_MASK)) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_MINOR_EOS;
            dclass = cfsl_pkg::CFSL_RECOV;
        end
        if (eng.first_scan_req & s_r.minor[cfsl_pkg::MB_RETAIN_LOST]) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_RETAIN_LOST;
            dclass = cfsl_pkg::CFSL_RECOV;
        end
        if (eng.fault_req) begin
            declare = 1'b1;
            dcode = eng.fault_code;
            dclass = eng.fault_class;
        end
        if (eng.pu_default_prog) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_DEFAULT_PROG;
            dclass = cfsl_pkg::CFSL_NON_USER;
        end
        if (eng.pu_unexp_reset) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_UNEXP_RESET;
            dclass = cfsl_pkg::CFSL_NON_USER;
        end
        if (eng.pu_nvm_corrupt) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_NVM_CORRUPT;
            dclass = cfsl_pkg::CFSL_NON_USER;
        end
        if (eng.pu_pgm_dev) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_PGM_DEV;
            dclass = cfsl_pkg::CFSL_NON_USER;
        end
        if (eng.pu_int_hw) begin
            declare = 1'b1;
            dcode = cfsl_pkg::FC_INT_HW;
            dclass = cfsl_pkg::CFSL_NON_USER;
        end
        if (declare & (s_r.mode == cfsl_pkg::CFSL_FAULT_RTN)) begin
            minor_set[cfsl_pkg::MB_FAULT_IN_FAULT] = 1'b1;
        end
        if (declare) begin
            irq_set[cfsl_pkg::IB_FAULT] = 1'b1;
        end

        // minor word: a written zero clears, a set in the same cycle wins
        minor_clr = wr_minor ? (~pwdata[15:0] & wmask) : 16'h0000;
        s_nxt.minor = ((s_r.minor & ~minor_clr) | minor_set)
            & cfsl_pkg::MINOR_IMPL_MASK;

        // major code: software write, hardware load overrides, no clear
        major_w = (pwdata[15:0] & wmask) | (s_r.major & ~wmask);
        if (wr_major) begin
            s_nxt.major = major_w;
        end
        if (declare) begin
            s_nxt.major = dcode;
        end

        // fault sequencing
        s_nxt.run_rtn = 1'b0;
        case (s_r.mode)
            cfsl_pkg::CFSL_RUN: begin
                if (declare) begin
                    s_nxt.halt = 1'b1;
                    s_nxt.cls = dclass;
                    if (dclass == cfsl_pkg::CFSL_NON_USER) begin
                        s_nxt.mode = cfsl_pkg::CFSL_HALTED;
                    end else begin
                        s_nxt.mode = cfsl_pkg::CFSL_FAULT_RTN;
                        s_nxt.run_rtn = 1'b1;
                    end
                end
            end
            cfsl_pkg::CFSL_FAULT_RTN: begin
                if (declare) begin
                    s_nxt.halt = 1'b1;
                    s_nxt.cls = cfsl_pkg::CFSL_NON_USER;
                    s_nxt.mode = cfsl_pkg::CFSL_HALTED;
                end else begin
                    if (sw_halt_clr & (s_r.cls == cfsl_pkg::CFSL_RECOV)) begin
                        s_nxt.halt = 1'b0;
                    end
                    if (eng.fault_rtn_done) begin
                        if (s_nxt.halt) begin
                            s_nxt.mode = cfsl_pkg::CFSL_HALTED;
                        end else begin
                            s_nxt.mode = cfsl_pkg::CFSL_RUN;
                        end
                    end
                end
            end
            cfsl_pkg::CFSL_HALTED: begin
                s_nxt.halt = 1'b1;
            end
            default: begin
                s_nxt.mode = cfsl_pkg::CFSL_HALTED;
            end
        endcase

        // interrupt status: write one to clear, set wins
        if (wr_istat) begin
            s_nxt.irq_stat = s_r.irq_stat & ~pwdata[cfsl_pkg::IRQ_W-1:0];
        end
        s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
        if (wr_imask) begin
            s_nxt.irq_mask = pwdata[cfsl_pkg::IRQ_W-1:0];
        end

        // read data captured in the setup cycle, answered in access
        if (setup_ph) begin
            s_nxt.pslverr = ~idx_ok;
            s_nxt.prdata = 32'h0000_0000;
            case (idx)
                cfsl_pkg::IDX_CTRL: s_nxt.prdata[cfsl_pkg::CB_HALT] = s_r.halt;
                cfsl_pkg::IDX_STATE: s_nxt.prdata[3:0] = {s_r.cls, s_r.mode};
                cfsl_pkg::IDX_MINOR: s_nxt.prdata[15:0] = s_r.minor;
                cfsl_pkg::IDX_MAJOR: s_nxt.prdata[15:0] = s_r.major;
                cfsl_pkg::IDX_IRQ_STAT: s_nxt.prdata[cfsl_pkg::IRQ_W-1:0] = s_r.irq_stat;
                cfsl_pkg::IDX_IRQ_MASK: s_nxt.prdata[cfsl_pkg::IRQ_W-1:0] = s_r.irq_mask;
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.minor <= cfsl_pkg::MINOR_RESET;
            s_r.major <= cfsl_pkg::MAJOR_RESET;
            s_r.halt <= 1'b0;
            s_r.cls <= cfsl_pkg::CFSL_NON_USER;
            s_r.mode <= cfsl_pkg::CFSL_RUN;
            s_r.run_rtn <= 1'b0;
            s_r.irq_stat <= cfsl_pkg::IRQ_RESET;
            s_r.irq_mask <= cfsl_pkg::IRQ_RESET;
            s_r.prdata <= 32'h0000_0000;
            s_r.pslverr <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pready = 1'b1; // zero wait states
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr & psel & penable;
    assign halt = s_r.halt;
    assign program_stop = (s_r.mode == cfsl_pkg::CFSL_HALTED);
    assign run_fault_routine = s_r.run_rtn;
    assign major_code = s_r.major;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);
endmodule : cfsl_top

// >>> tb/cfsl_engine_model.sv
// cfsl_engine_model: scan engine side of the fault-status logic.
// assumes: the bench calls pulse; same clock as the block.
`timescale 1ns/1ns
module cfsl_engine_model #(
    parameter int GAP = 0
) (
    input wire logic pclk,
    output cfsl_pkg::cfsl_engine_t eng
);
    // ------------------------------------------------------------
    // event driver
    // ------------------------------------------------------------
    initial begin
        eng = '0;
    end
    // holds one event set for exactly one cycle, then idles for GAP cycles
    task automatic pulse(input cfsl_pkg::cfsl_engine_t v);
        @(posedge pclk);
        eng <= v; // expiry travels with its busy and pending levels
        @(posedge pclk);
        eng <= '0;
        repeat (GAP) @(posedge pclk);
    endtask : pulse
endmodule : cfsl_engine_model

// >>> tb/cfsl_checker.sv
// cfsl_checker: port-level assertions for cfsl_top.
// assumes: bound to cfsl_top; one pclk domain, presetn async low.
`timescale 1ns/1ns
module cfsl_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cfsl_pkg::cfsl_engine_t eng,
    input wire logic halt,
    input wire logic program_stop,
    input wire logic run_fault_routine,
    input wire logic [15:0] major_code,
    input wire logic irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] idx;
    logic pu_any;
    logic in_rtn_r;
    logic maj_cause;
    assign idx = paddr[7:2];
    // anything that may legally change the major code word
    assign maj_cause = (psel && penable && pwrite && idx == 6'h06) || eng.fault_req || pu_any
        || eng.first_scan_req || eng.scan_end;
    assign pu_any = eng.pu_default_prog | eng.pu_unexp_reset | eng.pu_nvm_corrupt
        | eng.pu_pgm_dev | eng.pu_int_hw;
    // high while a fault routine runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_rtn_r <= 1'b0;
        end else if (run_fault_routine) begin
            in_rtn_r <= 1'b1;
        end else if (eng.fault_rtn_done || program_stop) begin
            in_rtn_r <= 1'b0;
        end
    end
    sequence s_rd_major;
        psel && !penable && !pwrite && idx == 6'h06 ##1 psel && penable;
    endsequence
    sequence s_user_fault;
        eng.fault_req && !pu_any && !program_stop && !in_rtn_r && !run_fault_routine
            && eng.fault_class != cfsl_pkg::CFSL_NON_USER;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_fault_loads_code: assert property (
        eng.fault_req && !pu_any |=> major_code == $past(eng.fault_code))
        else $error("major code not loaded by fault");
    a_hw_error_code: assert property (
        eng.pu_int_hw |=> major_code == 16'h0009 && program_stop)
        else $error("hardware error code wrong");
    a_nvm_code: assert property (
        eng.pu_nvm_corrupt && !eng.pu_int_hw && !eng.pu_pgm_dev |=> major_code == 16'h0003)
        else $error("memory corrupt code wrong");
    a_major_holds: assert property (
        !$stable(major_code) |-> $past(maj_cause))
        else $error("major code changed without cause");
    a_nonuser_stops: assert property (
        eng.fault_req && eng.fault_class == cfsl_pkg::CFSL_NON_USER
            |=> program_stop && !run_fault_routine)
        else $error("non-user fault did not stop");
    a_user_runs_rtn: assert property (
        s_user_fault |=> run_fault_routine && halt && !program_stop)
        else $error("user fault routine not started");
    a_halt_sticky: assert property (
        program_stop |=> program_stop)
        else $error("stopped program resumed");
    a_unmapped_err: assert property (
        psel && penable && !(idx inside {6'h00, 6'h02, 6'h05, 6'h06, 6'h08, 6'h09}) |-> pslverr)
        else $error("unmapped access not refused");
    a_reserved_zero: assert property (
        psel && penable && !pwrite && idx == 6'h05 |-> (prdata & 32'hFFFF_DAF2) == 32'h0)
        else $error("reserved minor bits not zero");
    a_major_read: assert property (
        s_rd_major |-> prdata == {16'h0000, $past(major_code)})
        else $error("major code read back wrong");
endmodule : cfsl_checker
bind cfsl_top cfsl_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng(eng),
    .halt(halt), .program_stop(program_stop), .run_fault_routine(run_fault_routine),
    .major_code(major_code), .irq(irq));

// >>> tb/tb.sv
// tb: self-checking bench for the controller fault-status logic.
// assumes: package, design, engine model and checker compiled first.
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic halt, program_stop, run_fault_routine, irq;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] major_code;
    logic [15:0] pu_code [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h0009};
    cfsl_pkg::cfsl_engine_t eng, ev;
    int fails = 0;
    int total_checks = 0;
    // ------------------------------------------------------------
    // design, engine model, clock
    // ------------------------------------------------------------
    cfsl_top #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eng(eng), .halt(halt), .program_stop(program_stop),
        .run_fault_routine(run_fault_routine), .major_code(major_code), .irq(irq));
    cfsl_engine_model u_eng (.pclk(pclk), .eng(eng));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_pin
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            $display("BAD %0t apb timeout", $time);
            end_of_test();
        end
        #1;
    endtask : apb
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic send();
        u_eng.pulse(ev);
        #1;
    endtask : send
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_flags();
        apb(1'b0, 8'h04, 32'h0);
        chk_pin(err, 1'b1);
        chk(rd, 32'h0);
        ev = '0;
        ev.pti_expire = 1'b1;
        ev.pti_busy = 1'b1;
        send();
        ev.pti_pending = 1'b1;
        send();
        ev = '0;
        ev.retain_lost = 1'b1;
        ev.filter_adjusted = 1'b1;
        ev.minor_set = 8'hFF;
        send();
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0000_2505);
        chk_pin(irq, 1'b0);
        apb(1'b1, 8'h24, 32'h0000_000F);
        chk_pin(irq, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_000E);
        apb(1'b1, 8'h20, 32'h0000_000E);
        chk_pin(irq, 1'b0);
    endtask : t_flags
    task automatic t_recover();
        ev = '0;
        ev.scan_end = 1'b1;
        send();
        chk({16'h0, major_code}, 32'h0000_0020);
        chk_pin(run_fault_routine, 1'b1);
        chk_pin(halt, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h14, 32'h0000_0100);
        ev = '0;
        ev.fault_rtn_done = 1'b1;
        send();
        chk({halt, program_stop}, 2'b00);
        ev = '0;
        ev.first_scan_req = 1'b1;
        send();
        chk({16'h0, major_code}, 32'h0000_0005);
        chk_pin(halt, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0000_0100);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        ev = '0;
        ev.fault_rtn_done = 1'b1;
        send();
        ev = '0;
        ev.first_scan_req = 1'b1;
        send();
        chk_pin(halt, 1'b0);
        chk({16'h0, major_code}, 32'h0000_0005);
    endtask : t_recover
    task automatic t_latched();
        ev = '0;
        ev.fault_req = 1'b1;
        ev.fault_class = cfsl_pkg::CFSL_NON_RECOV;
        ev.fault_code = 16'h0022;
        send();
        chk_pin(run_fault_routine, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        chk_pin(halt, 1'b1);
        ev = '0;
        ev.fault_rtn_done = 1'b1;
        send();
        chk_pin(program_stop, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0000_0022);
    endtask : t_latched
    task automatic t_sw_fault();
        apb(1'b1, 8'h18, 32'h0000_0ABC);
        apb(1'b1, 8'h00, 32'h0000_0001);
        chk_pin(halt, 1'b1);
        chk({16'h0, major_code}, 32'h0000_0ABC);
        ev = '0;
        ev.fault_req = 1'b1;
        ev.fault_class = cfsl_pkg::CFSL_NON_USER;
        ev.fault_code = 16'h0031;
        send();
        chk_pin(program_stop, 1'b1);
        chk({16'h0, major_code}, 32'h0000_0031);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h8, 32'h8);
    endtask : t_sw_fault
    task automatic t_powerup();
        for (int i = 0; i < 5; i++) begin
            ev = '0;
            case (i)
                0: ev.pu_default_prog = 1'b1;
                1: ev.pu_unexp_reset = 1'b1;
                2: ev.pu_nvm_corrupt = 1'b1;
                3: ev.pu_pgm_dev = 1'b1;
                default: ev.pu_int_hw = 1'b1;
            endcase
            send();
            chk({16'h0, major_code}, {16'h0, pu_code[i]});
            chk({program_stop, run_fault_routine}, 2'b10);
        end
    endtask : t_powerup
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ev = '0;
        do_reset();
        t_flags();
        t_recover();
        t_latched();
        do_reset();
        t_sw_fault();
        do_reset();
        t_powerup();
        end_of_test();
    end
endmodule : tb
